// file: src/ocpc_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef OCPC_DEFS_VH
`define OCPC_DEFS_VH
`define OCPC_ADDR_W          4
`define OCPC_REG_RAW         4'h4
`define OCPC_REG_OSC         4'h7
`define OCPC_REG_CFG         4'h8
`define OCPC_REG_CTRL        4'hA
`define OCPC_REG_STAT        4'hB
// Register 7 fields
`define OCPC_OSC_LO          0
`define OCPC_DIV_LO          2
`define OCPC_R7_RST          24'h000000
// Register 8 fields
`define OCPC_GAIN_LO         0
`define OCPC_TEMP_LO         4
`define OCPC_MFAKE_LO        8
`define OCPC_ONESHOT_BIT     12
`define OCPC_WHEAT_BIT       13
`define OCPC_GCON_LO         16
`define OCPC_GCON_HI         19
`define OCPC_GEN_BIT         20
`define OCPC_SLEEP_BIT       21
`define OCPC_R8_RST          24'h000000
// Control register bits
`define OCPC_CTRL_START      0
`define OCPC_CTRL_STOP       1
// Settle delays, clock frequency and slow tick divider
`define OCPC_SETTLE_SHORT_US 640
`define OCPC_SETTLE_LONG_US  1280
`define OCPC_CLK_MHZ         20
`define OCPC_SLOW_DIV        610
`endif

// file: src/ocpc_interval_reg.v
// Holding register for the raw interval value, read out of a flip-flop
`timescale 1ns/100ps
module ocpc_interval_reg #(
   parameter W = 24
) (
   input  wire         ref_clk,
   input  wire         rst_b,
   input  wire         wr_en,
   input  wire [W-1:0] wr_data,
   output reg  [W-1:0] rd_data
);
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= {W{1'b0}};
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end
endmodule // ocpc_interval_reg

// file: src/ocpc_top.v
// Oscillator start control and switched-comparator power gating
`timescale 1ns/100ps
`include "ocpc_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Raw discharge interval readable at register 4, in divided fast periods
// - Comparator disabled between single conversions and during recharge
// - Comparator disable timing follows the next sequencer state on every ref_clk cycle
// - Comparator gating settings sit in bits 16 to 21 of register 8
// - Gating enable turns feature on and repurposes both multi pins
// - Deep sleep: pin one high impedance, pin two driven high
// - Gating field: always on, off charging, off in idle, or both
// - Half bridge select toggles only in classic bridge mode
// - Oscillator control 0 stops oscillator, 1 runs it continuously
// - Value 2 starts oscillator on start, measures after 640 us
// - Value 3 as value 2 with 1280 us settling delay
// - Fast clock is interval predivider; divided fast clock alone times charge cycle
// - Fast clock divider codes 0..3 divide by 1, 2, 4, 8
// - Classic bridge mode enabled by its own bit in register 8
//////////////////////////////////////////////////////////////////////////////
module ocpc_top #(
   parameter CYC_W       = 12,
   parameter SHORT_TICKS = 21,
   parameter LONG_TICKS  = 42,
   parameter SLOW_DIV    = `OCPC_SLOW_DIV
) (
   input  wire        ref_clk,
   input  wire        rst_b,
   input  wire [3:0]  addr,
   input  wire [23:0] wr_data,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [23:0] rd_data,
   input  wire        ext_trigger,
   input  wire        cmp_in,
   input  wire        slow_clk_run,
   output reg         fast_osc_run,
   output reg         fast_clk_tick,
   output reg         charge_active,
   output reg         multi_pin_one,
   output reg         multi_pin_one_oe,
   output reg         multi_pin_two,
   output reg         multi_pin_two_oe,
   output reg         half_bridge_select_out,
   output reg         meas_busy
);
   localparam S_IDLE   = 5'b00001;
   localparam S_SETTLE = 5'b00010;
   localparam S_DISCH  = 5'b00100;
   localparam S_CHARGE = 5'b01000;
   localparam S_DONE   = 5'b10000;

   reg [23:0]      osc_reg_q;
   reg [23:0]      cfg_reg_q;
   reg [4:0]       state_q;
   reg [4:0]       state_d;
   reg [15:0]      slow_cnt_q;
   reg             slow_tick_q;
   reg [7:0]       settle_q;
   reg [2:0]       div_cnt_q;
   reg [23:0]      interval_q;
   reg [CYC_W-1:0] charge_q;
   reg             timeout_q;
   reg             raw_wr_q;
   wire [23:0]     raw_interval_value;

   wire [1:0] fast_osc_control   = osc_reg_q[`OCPC_OSC_LO+1:`OCPC_OSC_LO];
   wire [1:0] fast_clock_divider = osc_reg_q[`OCPC_DIV_LO+1:`OCPC_DIV_LO];
   wire [3:0] gain_fix_rate      = cfg_reg_q[`OCPC_GAIN_LO+3:`OCPC_GAIN_LO];
   wire [3:0] cmp_gating_field   = cfg_reg_q[`OCPC_GCON_HI:`OCPC_GCON_LO];
   wire       cmp_gating_enable  = cfg_reg_q[`OCPC_GEN_BIT];
   wire       cmp_deep_sleep     = cfg_reg_q[`OCPC_SLEEP_BIT];
   wire       one_shot_conversion  = cfg_reg_q[`OCPC_ONESHOT_BIT];
   wire       classic_bridge_enable = cfg_reg_q[`OCPC_WHEAT_BIT];

   wire wr_ctrl = wr_stb && (addr == `OCPC_REG_CTRL);
   wire start_req = (wr_ctrl && wr_data[`OCPC_CTRL_START]) || ext_trigger;
   wire stop_req  = wr_ctrl && wr_data[`OCPC_CTRL_STOP];

   // Divider terminal count for codes 0..3 -> /1 /2 /4 /8
   function [2:0] div_last;
      input [1:0] code;
      begin
         case (code)
            2'h0:    div_last = 3'h0;
            2'h1:    div_last = 3'h1;
            2'h2:    div_last = 3'h3;
            default: div_last = 3'h7;
         endcase
      end
   endfunction

   function [7:0] settle_ticks;
      input [1:0] code;
      begin
         if (code == 2'h3) begin
            settle_ticks = LONG_TICKS[7:0];
         end else begin
            settle_ticks = SHORT_TICKS[7:0];
         end
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_reg_q <= `OCPC_R7_RST;
         cfg_reg_q <= `OCPC_R8_RST;
      end else if (wr_stb) begin
         if (addr == `OCPC_REG_OSC) begin
            osc_reg_q <= wr_data;
         end
         if (addr == `OCPC_REG_CFG) begin
            cfg_reg_q <= wr_data;
         end
      end
   end

   // Read data stands the cycle after the strobe only
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 24'h000000;
      end else if (rd_stb) begin
         case (addr)
            `OCPC_REG_RAW:  rd_data <= raw_interval_value;
            `OCPC_REG_OSC:  rd_data <= osc_reg_q;
            `OCPC_REG_CFG:  rd_data <= cfg_reg_q;
            `OCPC_REG_STAT: rd_data <= {20'h00000, timeout_q, state_q[4:2] != 3'h0,
                                        fast_osc_run, slow_clk_run};
            default:        rd_data <= 24'h000000;
         endcase
      end else begin
         rd_data <= 24'h000000;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Slow clock tick: about 32 kHz from ref_clk while slow clock runs
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_cnt_q  <= 16'h0000;
         slow_tick_q <= 1'b0;
      end else if (slow_cnt_q == SLOW_DIV[15:0] - 16'h0001) begin
         slow_cnt_q  <= 16'h0000;
         slow_tick_q <= slow_clk_run;
      end else begin
         slow_cnt_q  <= slow_cnt_q + 16'h0001;
         slow_tick_q <= 1'b0;
      end
   end

   // Fast clock divider, runs only while oscillator runs
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_q     <= 3'h0;
         fast_clk_tick <= 1'b0;
      end else if (!fast_osc_run) begin
         div_cnt_q     <= 3'h0;
         fast_clk_tick <= 1'b0;
      end else if (div_cnt_q >= div_last(fast_clock_divider)) begin
         div_cnt_q     <= 3'h0;
         fast_clk_tick <= 1'b1;
      end else begin
         div_cnt_q     <= div_cnt_q + 3'h1;
         fast_clk_tick <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Measurement sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (start_req && fast_osc_control != 2'h0) begin
               if (fast_osc_control == 2'h1) begin
                  state_d = S_DISCH;
               end else begin
                  state_d = S_SETTLE;
               end
            end
         end
         S_SETTLE: begin
            if (slow_tick_q && settle_q <= 8'h01) begin
               state_d = S_DISCH;
            end
         end
         S_DISCH: begin
            if (cmp_in || (&interval_q)) begin
               state_d = S_CHARGE;
            end
         end
         S_CHARGE: begin
            if (fast_clk_tick && (&charge_q)) begin
               state_d = S_DONE;
            end
         end
         S_DONE: begin
            if (one_shot_conversion || stop_req) begin
               state_d = S_IDLE;
            end else begin
               state_d = S_DISCH;
            end
         end
         default: state_d = S_IDLE;
      endcase
      if (stop_req) begin
         state_d = S_IDLE;
      end
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= S_IDLE;
         settle_q   <= 8'h00;
         interval_q <= 24'h000000;
         charge_q   <= {CYC_W{1'b0}};
         timeout_q  <= 1'b0;
         raw_wr_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         raw_wr_q <= 1'b0;
         if (state_q == S_IDLE) begin
            settle_q <= settle_ticks(fast_osc_control);
         end else if (state_q == S_SETTLE && slow_tick_q) begin
            settle_q <= settle_q - 8'h01;
         end
         if (state_q != S_DISCH) begin
            interval_q <= 24'h000000;
         end else if (fast_clk_tick) begin
            interval_q <= interval_q + 24'h000001;
         end
         if (state_q == S_DISCH && state_d == S_CHARGE) begin
            raw_wr_q  <= 1'b1;
            timeout_q <= &interval_q;
         end
         if (state_q != S_CHARGE) begin
            charge_q <= {CYC_W{1'b0}};
         end else if (fast_clk_tick) begin
            charge_q <= charge_q + {{(CYC_W-1){1'b0}}, 1'b1};
         end
      end
   end

   ocpc_interval_reg #(
      .W (24)
   ) u_raw (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (raw_wr_q),
      .wr_data (interval_q),
      .rd_data (raw_interval_value)
   );

   //////////////////////////////////////////////////////////////////////////
   // Outputs and comparator gating
   reg cmp_on_d;
   always @* begin
      cmp_on_d = 1'b1;
      case (cmp_gating_field[1:0])
         2'h0: cmp_on_d = 1'b1;
         2'h1: cmp_on_d = (state_d != S_CHARGE);
         2'h2: cmp_on_d = (state_d != S_IDLE);
         default: cmp_on_d = (state_d != S_IDLE) && (state_d != S_CHARGE);
      endcase
      // Discharge always forces the comparator on, whatever the gating field
      if (state_d == S_DISCH) begin
         cmp_on_d = 1'b1;
      end
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_osc_run           <= 1'b0;
         charge_active          <= 1'b0;
         meas_busy              <= 1'b0;
         multi_pin_one          <= 1'b0;
         multi_pin_one_oe       <= 1'b0;
         multi_pin_two          <= 1'b0;
         multi_pin_two_oe       <= 1'b0;
         half_bridge_select_out <= 1'b0;
      end else begin
         fast_osc_run  <= (fast_osc_control == 2'h1) ||
                          (fast_osc_control[1] && state_d != S_IDLE);
         charge_active <= (state_d == S_CHARGE);
         meas_busy     <= (state_d != S_IDLE);
         if (!cmp_gating_enable) begin
            multi_pin_one_oe <= 1'b0;
            multi_pin_two_oe <= 1'b0;
            multi_pin_one    <= 1'b0;
            multi_pin_two    <= 1'b0;
         end else if (cmp_deep_sleep) begin
            multi_pin_one_oe <= 1'b0;
            multi_pin_one    <= 1'b0;
            multi_pin_two_oe <= 1'b1;
            multi_pin_two    <= 1'b1;
         end else begin
            // Both pins carry the disable level, high means comparator off
            multi_pin_one_oe <= 1'b1;
            multi_pin_two_oe <= 1'b1;
            multi_pin_one    <= ~cmp_on_d;
            multi_pin_two    <= ~cmp_on_d;
         end
         if (!classic_bridge_enable) begin
            half_bridge_select_out <= 1'b0;
         end else if (state_q == S_DONE) begin
            half_bridge_select_out <= ~half_bridge_select_out;
         end
      end
   end
   // Host-side duties are not checked here
   wire unused_ok = |gain_fix_rate;
endmodule // ocpc_top

// file: verification/ocpc_cmp_model.sv
// Behavioural model of the switched external discharge comparator
`timescale 1ns/100ps
module ocpc_cmp_model #(
   parameter DLY = 5
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic fast_clk_tick,
   input  wire logic charge_active,
   input  wire logic meas_busy,
   input  wire logic multi_pin_two,
   input  wire logic multi_pin_two_oe,
   output logic      cmp_in
);
   logic [7:0] cnt_q;
   wire        powered = !(multi_pin_two_oe && multi_pin_two);
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= 8'h00;
         cmp_in <= 1'b0;
      end else begin
         if (charge_active || !meas_busy || !powered)
            cnt_q <= 8'h00;
         else if (fast_clk_tick && cnt_q != 8'hFF)
            cnt_q <= cnt_q + 8'h01;
         // Unpowered output means nothing, so it wanders each cycle
         cmp_in <= powered ? (cnt_q >= DLY) : ~cmp_in;
      end
   end
endmodule // ocpc_cmp_model

// file: verification/ocpc_top_props.sv
// Port assertions for the oscillator and comparator gating block
`timescale 1ns/100ps
module ocpc_top_props (
   input logic        ref_clk,
   input logic        rst_b,
   input logic [3:0]  addr,
   input logic [23:0] wr_data,
   input logic        wr_stb,
   input logic        rd_stb,
   input logic [23:0] rd_data,
   input logic        fast_osc_run,
   input logic        charge_active,
   input logic        multi_pin_one,
   input logic        multi_pin_one_oe,
   input logic        multi_pin_two,
   input logic        multi_pin_two_oe,
   input logic        half_bridge_select_out,
   input logic        meas_busy
);
   logic [23:0] cfg_q;
   logic [1:0]  osc_q;
   logic [1:0]  stl_q;
   wire         wr_cfg = wr_stb && addr == 4'h8;
   wire         wr_osc = wr_stb && addr == 4'h7;
   wire         stl    = stl_q == 2'h3;
   wire         gated  = stl && cfg_q[20] && !cfg_q[21];
   wire [3:0]   pins   = {multi_pin_one_oe, multi_pin_one, multi_pin_two_oe, multi_pin_two};
   // Shadow settings are trusted only once the pins had time to follow a write
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= 24'h000000;
         osc_q <= 2'h0;
         stl_q <= 2'h0;
      end else begin
         if (wr_cfg) cfg_q <= wr_data;
         if (wr_osc) osc_q <= wr_data[1:0];
         stl_q <= (wr_cfg || wr_osc) ? 2'h0 : stl_q + {1'b0, !stl};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_gate_off_pins: assert property (stl && !cfg_q[20] |-> !pins[3] && !pins[1])
      else $error("pins driven with gating off");
   a_deep_sleep_pins: assert property (stl && cfg_q[20] && cfg_q[21] |->
      pins[3:1] == 3'h1 && pins[0])
      else $error("sleep pin levels wrong");
   a_charge_cmp_off: assert property (gated && cfg_q[16] && charge_active
      && $past(charge_active) |-> pins == 4'hF)
      else $error("comparator powered while charging");
   // Idle with a free-running oscillator may legally gate the comparator off
   a_disch_cmp_on: assert property (gated && meas_busy && fast_osc_run && $past(fast_osc_run)
      && !charge_active && !$past(charge_active) |-> pins == 4'hA)
      else $error("comparator off with oscillator running");
   a_osc_code_zero: assert property (stl && osc_q == 2'h0 |-> !fast_osc_run)
      else $error("oscillator runs with code zero");
   a_osc_code_one: assert property (stl && osc_q == 2'h1 |-> fast_osc_run)
      else $error("oscillator stopped with code one");
   a_rd_data_idle: assert property (!$past(rd_stb) |-> rd_data == 24'h000000)
      else $error("read data outside its cycle");
   a_bridge_sel_hold: assert property (stl && !cfg_q[13] |=>
      $stable(half_bridge_select_out))
      else $error("bridge select moved outside bridge mode");
   c_charge: cover property (gated && charge_active);
   c_sleep: cover property (stl && cfg_q[21]);
   c_bridge: cover property ($rose(half_bridge_select_out));
endmodule // ocpc_top_props

// file: verification/tb_osc_and_comparator_power_control.sv
// Self-checking bench for the oscillator and comparator gating block
`timescale 1ns/100ps
module tb_osc_and_comparator_power_control;
   typedef struct {logic [23:0] cfg; logic [3:0] pins;} ocpc_row_t;
   localparam DLY = 5;
   logic        ref_clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
   logic        ext_trigger = 1'b0, slow_clk_run = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [23:0] wr_data = 24'h000000, d;
   wire  [23:0] rd_data;
   wire         cmp_in, osc, tick, chg, busy, p1, p1_oe, p2, p2_oe, hb;
   int          miscompares = 0, checks_done = 0, n, k;
   ocpc_row_t   rows [6] = '{'{24'h000000, 4'h0}, '{24'h100000, 4'hA}, '{24'h110000, 4'hA},
                             '{24'h120000, 4'hF}, '{24'h130000, 4'hF}, '{24'h300300, 4'h3}};
   always #25 ref_clk = ~ref_clk;
   ocpc_top #(.CYC_W(3), .SHORT_TICKS(5), .LONG_TICKS(10), .SLOW_DIV(4)) dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .ext_trigger(ext_trigger), .cmp_in(cmp_in),
      .slow_clk_run(slow_clk_run), .fast_osc_run(osc), .fast_clk_tick(tick),
      .charge_active(chg), .multi_pin_one(p1), .multi_pin_one_oe(p1_oe), .multi_pin_two(p2),
      .multi_pin_two_oe(p2_oe), .half_bridge_select_out(hb), .meas_busy(busy));
   ocpc_cmp_model #(.DLY(DLY)) model_u (.ref_clk(ref_clk), .rst_b(rst_b),
      .fast_clk_tick(tick), .charge_active(chg), .meas_busy(busy), .multi_pin_two(p2),
      .multi_pin_two_oe(p2_oe), .cmp_in(cmp_in));
   //////////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [23:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [23:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask
   // Bounded wait: 0 charge starts, 1 sequencer idle, 2 divided tick
   task automatic wt(input int s, input int lim, output int c);
      c = 0;
      while ((s == 0 ? chg : s == 1 ? !busy : tick) !== 1'b1) begin
         if (c == lim) begin
            miscompares++;
            $display("[ERR] wait %0d ran out", s);
            finish_test();
         end
         cyc(1);
         c++;
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(3);
      rst_b <= 1'b1;
      wr(4'h4, 24'hABCDEF);
      for (k = 3; k < 9; k++) begin
         rd(k[3:0], d);
         chk("reset or refused read", d, 24'h000000);
      end
      foreach (rows[i]) begin
         wr(4'h8, rows[i].cfg);
         cyc(3);
         chk("pins", {p1_oe, p1_oe & p1, p2_oe, p2}, rows[i].pins);
         rd(4'h8, d);
         chk("cfg readback", d, rows[i].cfg);
      end
      for (k = 0; k < 4; k++) begin
         wr(4'h7, 24'h000001 | 24'(k << 2));
         cyc(10);
         wt(2, 20, n);
         cyc(1);
         wt(2, 20, n);
         chk("tick period", n + 1, 1 << k);
      end
      wr(4'h7, 24'h000001);
      wr(4'h8, 24'h111000);
      wr(4'hA, 24'h000001);
      wt(0, 100, n);
      cyc(2);
      chk("pins in charge", {p1, p2}, 2'h3);
      wt(1, 200, n);
      rd(4'h4, d);
      chk("raw interval", d >= DLY - 1 && d <= DLY + 3, 1'b1);
      chk("osc stays on", osc, 1'b1);
      wr(4'h7, 24'h000000);
      wr(4'hA, 24'h000001);
      cyc(10);
      chk("start ignored", busy, 1'b0);
      wr(4'h8, 24'h131000);
      for (k = 2; k < 4; k++) begin
         wr(4'h7, 24'(k));
         ext_trigger <= 1'b1;
         cyc(1);
         ext_trigger <= 1'b0;
         cyc(2);
         chk("osc started", osc, 1'b1);
         wt(0, 200, n);
         // Slow tick phase is unknown, so the lower bound loses one tick
         chk("settle delay", n >= 20 * (k - 1) - 7 && n <= 20 * (k - 1) + 15, 1'b1);
         wt(1, 200, n);
         chk("osc stopped", osc, 1'b0);
      end
      // Without the slow clock the settle phase must never end
      slow_clk_run <= 1'b0;
      wr(4'h7, 24'h000002);
      wr(4'hA, 24'h000001);
      cyc(60);
      chk("settle held", {busy, chg}, 2'h2);
      rd(4'hB, d);
      chk("status in settle", d, 24'h000002);
      wr(4'hA, 24'h000002);
      slow_clk_run <= 1'b1;
      wr(4'h7, 24'h000001);
      wr(4'h8, 24'h002000);
      wr(4'hA, 24'h000001);
      k = 0;
      repeat (200) begin
         d[0] = hb;
         cyc(1);
         if (hb !== d[0]) k++;
      end
      chk("bridge toggles", k >= 4, 1'b1);
      wr(4'hA, 24'h000002);
      wt(1, 50, n);
      finish_test();
   end
endmodule // tb_osc_and_comparator_power_control

bind ocpc_top ocpc_top_props props_u (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
   .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
   .fast_osc_run(fast_osc_run), .charge_active(charge_active), .multi_pin_one(multi_pin_one),
   .multi_pin_one_oe(multi_pin_one_oe), .multi_pin_two(multi_pin_two),
   .multi_pin_two_oe(multi_pin_two_oe), .half_bridge_select_out(half_bridge_select_out),
   .meas_busy(meas_busy));
